// ---- logic/bpc_top.sv ----
// Added by the designer: strobed register access.
`include "bpc_cfg.svh"

module bpc_top
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // register port
   input wire bpc_pkg::bpc_req_t req,
   output logic [7:0] rdata,
   // cpu bus and pipeline
   input wire bpc_pkg::bpc_cycle_t cyc,
   input wire logic insn_boundary,
   input wire logic tag_exec,
   input wire logic tag_flush,
   // arming and mode from the rest of the debug unit
   input wire logic arm_pulse,
   input wire logic first_loop_capture,
   input wire logic trace_debugger_enable_request,
   // break requests toward the cpu
   output logic brk_swi,
   output logic brk_bdm,
   // controls toward comparators a and b
   output logic trace_debugger_enable_allowed,
   output logic full_mode_eff,
   output logic ab_tag_eff,
   output logic [1:0] first_addr_mask_eff,
   output logic [1:0] second_addr_mask_eff,
   // interrupt
   output logic irq
);

   bpc_pkg::bpc_state_t q;
   bpc_pkg::bpc_state_t d;

   // ============================================================
   // address decode, shared by write and read paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ============================================================
   // comparator c match
   logic bkp_mode;
   logic c_active;
   logic addr_ok;
   logic page_ok;
   logic dir_ok;
   logic match;
   logic loop_arm;
   logic [7:0] c3_view;

   always_comb
   begin
      bkp_mode = q.c2[`BPC_C2_ABEN];
      // in trace mode the loop capture borrows comparator c, so it never breaks then
      c_active = q.c2[`BPC_C2_CEN] && (bkp_mode || !first_loop_capture);
      if (q.ccx[`BPC_CCX_PAGE_LO])
      begin
         // paged: high byte takes expanded bits 15..14 in place of cpu bits
         page_ok = (q.ccx[`BPC_CCX_EXT_HI:`BPC_CCX_EXT_LO] == cyc.xaddr[21:16]);
         addr_ok = (q.cch == {cyc.xaddr[15:14], cyc.addr[13:8]}) &&
            (q.ccl == cyc.addr[7:0]);
      end
      else
      begin
         page_ok = 1'b1;
         addr_ok = ({q.cch, q.ccl} == cyc.addr);
      end
      // direction has no meaning for tagged opcodes, so it is skipped there
      if (q.c2[`BPC_C2_C_DIRECTION_QUALIFY_ENABLE] && !q.c2[`BPC_C2_C_TAG_SELECT])
         dir_ok = (cyc.read == q.c2[`BPC_C2_RWC]);
      else
         dir_ok = 1'b1;
      match = cyc.valid && c_active && addr_ok && page_ok && dir_ok;
      loop_arm = arm_pulse && first_loop_capture;
      c3_view = q.c3;
      if (!bkp_mode)
         c3_view[`BPC_C3_AMASK_HI:`BPC_C3_AMASK_LO] = 2'h0;
   end

   // ============================================================
   // next state
   logic issue;
   logic [1:0] evt;

   always_comb
   begin
      d = q;
      issue = 1'b0;
      // register writes
      if (req.wr)
      begin
         if (hit(req.addr, `BPC_OFF_CCX))
            d.ccx = req.wdata;
         if (hit(req.addr, `BPC_OFF_CCH))
            d.cch = req.wdata;
         if (hit(req.addr, `BPC_OFF_CCL))
            d.ccl = req.wdata;
         if (hit(req.addr, `BPC_OFF_C2))
            d.c2 = req.wdata;
         if (hit(req.addr, `BPC_OFF_C3))
            d.c3 = req.wdata;
         if (hit(req.addr, `BPC_OFF_MSK))
            d.msk = req.wdata[1:0];
      end
      // arming in loop capture wins over a software write in the same cycle
      if (loop_arm)
      begin
         d.cch = `BPC_RST_BYTE;
         d.ccl = `BPC_RST_BYTE;
         d.c2[`BPC_C2_CEN] = 1'b0;
      end
      // register reads, answer stands one cycle later
      d.rdata = `BPC_RST_BYTE;
      if (req.rd)
      begin
         if (hit(req.addr, `BPC_OFF_CCX))
            d.rdata = q.ccx;
         else if (hit(req.addr, `BPC_OFF_CCH))
            d.rdata = q.cch;
         else if (hit(req.addr, `BPC_OFF_CCL))
            d.rdata = q.ccl;
         else if (hit(req.addr, `BPC_OFF_C2))
            d.rdata = q.c2;
         else if (hit(req.addr, `BPC_OFF_C3))
            d.rdata = c3_view;
         else if (hit(req.addr, `BPC_OFF_STS))
            d.rdata = {6'h00, q.sts};
         else if (hit(req.addr, `BPC_OFF_MSK))
            d.rdata = {6'h00, q.msk};
      end
      // break timing
      case (q.pend)
         bpc_pkg::BPC_IDLE:
         begin
            if (match)
               d.pend = q.c2[`BPC_C2_C_TAG_SELECT] ? bpc_pkg::BPC_TAG : bpc_pkg::BPC_FORCE;
         end
         bpc_pkg::BPC_FORCE:
         begin
            if (insn_boundary)
            begin
               issue = 1'b1;
               d.pend = bpc_pkg::BPC_IDLE;
            end
         end
         bpc_pkg::BPC_TAG:
         begin
            if (tag_exec)
            begin
               issue = 1'b1;
               d.pend = bpc_pkg::BPC_IDLE;
            end
            else if (tag_flush)
               d.pend = bpc_pkg::BPC_IDLE;
         end
         default:
            d.pend = bpc_pkg::BPC_IDLE;
      endcase
      // disabling comparator c drops a pending break
      if (!c_active)
         d.pend = bpc_pkg::BPC_IDLE;
      d.brk_swi = issue && !q.c2[`BPC_C2_BDM];
      d.brk_bdm = issue && q.c2[`BPC_C2_BDM];
      d.c_match = match;
      // sticky events: a new event wins over a write-one clear
      evt = `BPC_RST_EVT;
      evt[`BPC_EVT_MATCH] = match;
      evt[`BPC_EVT_BREAK] = issue;
      if (req.wr && hit(req.addr, `BPC_OFF_STS))
         d.sts = (q.sts & ~req.wdata[1:0]) | evt;
      else
         d.sts = q.sts | evt;
      d.irq = |(q.sts & q.msk);
      // outputs toward the rest of the debug unit
      d.trace_debugger_enable_ok = trace_debugger_enable_request && !bkp_mode;
      d.full_eff = bkp_mode && q.c2[`BPC_C2_FULL];
      d.ab_tag_eff = bkp_mode && q.c2[`BPC_C2_AB_TAG_SELECT];
      d.amask_eff = c3_view[`BPC_C3_AMASK_HI:`BPC_C3_AMASK_LO];
      // in trace mode the second masks only qualify data in full mode
      if (bkp_mode || q.c2[`BPC_C2_FULL])
         d.bmask_eff = q.c3[`BPC_C3_BMASK_HI:`BPC_C3_BMASK_LO];
      else
         d.bmask_eff = 2'h0;
   end

   // ============================================================
   // state register
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         q <= '0;
         q.pend <= bpc_pkg::BPC_IDLE;
      end
      else
         q <= d;
   end

   assign rdata = q.rdata;
   assign brk_swi = q.brk_swi;
   assign brk_bdm = q.brk_bdm;
   assign trace_debugger_enable_allowed = q.trace_debugger_enable_ok;
   assign full_mode_eff = q.full_eff;
   assign ab_tag_eff = q.ab_tag_eff;
   assign first_addr_mask_eff = q.amask_eff;
   assign second_addr_mask_eff = q.bmask_eff;
   assign irq = q.irq;

   // ============================================================
   // checks
   sequence s_force_wait;
      (q.pend == bpc_pkg::BPC_FORCE) && c_active ##0 insn_boundary;
   endsequence

   sequence s_tag_drop;
      (q.pend == bpc_pkg::BPC_TAG) && !tag_exec ##0 tag_flush;
   endsequence

   chk_trace_debugger_enable_block: assert property (@(posedge mclk) disable iff (!rst_n)
      q.c2[`BPC_C2_ABEN] |=> !trace_debugger_enable_allowed)
      else $error("trace enable passed in breakpoint mode");

   chk_loop_clear: assert property (@(posedge mclk) disable iff (!rst_n)
      loop_arm |=> (q.cch == 8'h00) && (q.ccl == 8'h00) && !q.c2[`BPC_C2_CEN])
      else $error("loop arm did not clear comparator c");

   chk_force_break: assert property (@(posedge mclk) disable iff (!rst_n)
      s_force_wait |=> (brk_swi || brk_bdm))
      else $error("forced break not issued at boundary");

   chk_tag_discard: assert property (@(posedge mclk) disable iff (!rst_n)
      s_tag_drop |=> !brk_swi && !brk_bdm && (q.pend == bpc_pkg::BPC_IDLE))
      else $error("discarded tagged opcode broke");

   chk_break_dest: assert property (@(posedge mclk) disable iff (!rst_n)
      (brk_swi || brk_bdm) |-> (brk_bdm == $past(q.c2[`BPC_C2_BDM])) && !(brk_swi && brk_bdm))
      else $error("break sent to wrong destination");

   chk_trace_masks: assert property (@(posedge mclk) disable iff (!rst_n)
      !q.c2[`BPC_C2_ABEN] |=> (first_addr_mask_eff == 2'h0) && !full_mode_eff && !ab_tag_eff)
      else $error("trace mode left ab controls active");

   chk_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
      (|(q.sts & q.msk)) |=> irq)
      else $error("interrupt not raised for unmasked event");

   chk_match_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      match |=> q.sts[`BPC_EVT_MATCH])
      else $error("match event not recorded");

   chk_read_timing: assert property (@(posedge mclk) disable iff (!rst_n)
      (req.rd && hit(req.addr, `BPC_OFF_CCL)) |=> (rdata == $past(q.ccl)) ##1 (rdata == 8'h00)
      || $past(req.rd, 1))
      else $error("read data not in the following cycle");

   chk_loop_silent: assert property (@(posedge mclk) disable iff (!rst_n)
      (!q.c2[`BPC_C2_ABEN] && first_loop_capture) |-> !match)
      else $error("comparator c matched during loop capture");
endmodule

// ---- logic/bpc_cfg.svh ----
`ifndef BPC_CFG_SVH
`define BPC_CFG_SVH
// How it works
// - compare_c_value matches cpu address bits 15..0
// - arming in first loop clears compare value
// - ab breakpoint enable blocks trace debugger enable
// - trace mode ignores ab tag, and full only gates the second masks
// - comparator c works except first loop capture in trace mode
// - full select: dual addresses or address plus data
// - destination bit picks software trap or halt
// - ab tag: force at boundary or tagged
// - c tag: force at boundary or tagged
// - discarded tagged opcode never breaks
// - c enable bit, cleared on first loop arm
// - direction qualify enable, ignored when tagged
// - direction value: 0 write, 1 read
// - trace mode forces first address masks zero
// - trace full mode uses second masks for data
// - program paging compares extended bits 21..16
// - page selector upper bit is ignored
// ============================================================
// register offsets
`define BPC_OFF_CCX 8'h25
`define BPC_OFF_CCH 8'h26
`define BPC_OFF_CCL 8'h27
`define BPC_OFF_C2 8'h28
`define BPC_OFF_C3 8'h29
`define BPC_OFF_STS 8'h2a
`define BPC_OFF_MSK 8'h2b
// ============================================================
// reset values
`define BPC_RST_BYTE 8'h00
`define BPC_RST_EVT 2'h0
// ============================================================
// breakpoint_control fields
`define BPC_C2_ABEN 7
`define BPC_C2_FULL 6
`define BPC_C2_BDM 5
`define BPC_C2_AB_TAG_SELECT 4
`define BPC_C2_CEN 3
`define BPC_C2_C_TAG_SELECT 2
`define BPC_C2_C_DIRECTION_QUALIFY_ENABLE 1
`define BPC_C2_RWC 0
// ============================================================
// extended register and mask control fields
`define BPC_CCX_PAGE_LO 6
`define BPC_CCX_EXT_HI 5
`define BPC_CCX_EXT_LO 0
`define BPC_C3_AMASK_HI 7
`define BPC_C3_AMASK_LO 6
`define BPC_C3_BMASK_HI 5
`define BPC_C3_BMASK_LO 4
// ============================================================
// event bits in status and mask
`define BPC_EVT_MATCH 0
`define BPC_EVT_BREAK 1
`endif

// ---- logic/bpc_pkg.sv ----
package bpc_pkg;
   // ============================================================
   // break pending state
   typedef enum logic [1:0]
   {
      BPC_IDLE = 2'b00,
      BPC_FORCE = 2'b01,
      BPC_TAG = 2'b10
   } bpc_pend_t;
   // ============================================================
   // register port request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bpc_req_t;
   // ============================================================
   // cpu bus cycle as seen by the comparator
   typedef struct packed
   {
      logic valid;
      logic read;
      logic [21:14] xaddr;
      logic [15:0] addr;
   } bpc_cycle_t;
   // ============================================================
   // all block state
   typedef struct packed
   {
      logic [7:0] ccx;
      logic [7:0] cch;
      logic [7:0] ccl;
      logic [7:0] c2;
      logic [7:0] c3;
      logic [1:0] sts;
      logic [1:0] msk;
      logic [7:0] rdata;
      bpc_pend_t pend;
      logic brk_swi;
      logic brk_bdm;
      logic irq;
      logic trace_debugger_enable_ok;
      logic full_eff;
      logic ab_tag_eff;
      logic [1:0] amask_eff;
      logic [1:0] bmask_eff;
      logic c_match;
   } bpc_state_t;
endpackage

// ---- dv/bpc_cpu_model.sv ----
module bpc_cpu_model
(
   // clock
   input wire logic mclk,
   // bus cycle and pipeline events
   output bpc_pkg::bpc_cycle_t cyc,
   output logic insn_boundary,
   output logic tag_exec,
   output logic tag_flush
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      cyc = '0;
      {tag_flush, tag_exec, insn_boundary} = 3'h0;
   end
   // ============================================================
   // bus cycle; afterwards the lines flip so a stale address never matches by luck
   task automatic bus(input logic rd, input logic [7:0] xa, input logic [15:0] a);
      @(posedge mclk);
      cyc <= '{1'b1, rd, xa, a};
      @(posedge mclk);
      cyc <= '{1'b0, ~rd, ~xa, ~a};
   endtask
   // ============================================================
   // ev is one-hot {flush, exec, boundary}, always later than the match
   task automatic pipe(input logic [2:0] ev);
      @(posedge mclk);
      {tag_flush, tag_exec, insn_boundary} <= ev;
      @(posedge mclk);
      {tag_flush, tag_exec, insn_boundary} <= 3'h0;
   endtask
endmodule

// ---- dv/bpc_top_tb.sv ----
module bpc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed
   {
      logic [7:0] c2;
      logic [7:0] ccx;
      logic [7:0] cch;
      logic r;
      logic [7:0] xa;
      logic [15:0] a;
      logic [2:0] ev;
      logic [1:0] exp;
   } bpc_case_t;
   logic mclk, rst_n, arm_pulse, first_loop_capture, trace_debugger_enable_request;
   bpc_pkg::bpc_req_t req;
   bpc_pkg::bpc_cycle_t cyc;
   logic insn_boundary, tag_exec, tag_flush, brk_swi, brk_bdm, irq;
   logic trace_debugger_enable_allowed, full_mode_eff, ab_tag_eff;
   logic [1:0] first_addr_mask_eff, second_addr_mask_eff;
   logic [7:0] rdata, rd_val;
   int error_cnt, num_checks;
   logic [7:0] pat [0:4] = '{8'h41, 8'ha5, 8'h5a, 8'hff, 8'hf0};
   // {c2, ccx, cch, read, xaddr, addr, event, {swi, bdm}}
   bpc_case_t cases [0:17] = '{
      {8'h88, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h2},
      {8'ha8, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h1},
      {8'h88, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1235, 3'h1, 2'h0},
      {8'h80, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h0},
      {8'h8b, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h0},
      {8'h8b, 8'h00, 8'h12, 1'b1, 8'h00, 16'h1234, 3'h1, 2'h2},
      {8'h8a, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h2},
      {8'h89, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h2},
      {8'h8c, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h0},
      {8'h8c, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h2, 2'h2},
      {8'h8f, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h2, 2'h2},
      {8'h8c, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h4, 2'h0},
      {8'h8c, 8'h00, 8'h12, 1'b0, 8'h00, 16'h5555, 3'h2, 2'h0},
      {8'h88, 8'h45, 8'hd2, 1'b0, 8'h17, 16'h1234, 3'h1, 2'h2},
      {8'h88, 8'h45, 8'hd2, 1'b0, 8'h1b, 16'h1234, 3'h1, 2'h0},
      {8'h88, 8'hc5, 8'hd2, 1'b0, 8'h17, 16'h1234, 3'h1, 2'h2},
      {8'h88, 8'h80, 8'h12, 1'b0, 8'h1b, 16'h1234, 3'h1, 2'h2},
      {8'h08, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h2}};
   bpc_top u_dut (.mclk, .rst_n, .req, .rdata, .cyc, .insn_boundary, .tag_exec, .tag_flush,
      .arm_pulse, .first_loop_capture, .trace_debugger_enable_request, .brk_swi, .brk_bdm, .trace_debugger_enable_allowed,
      .full_mode_eff, .ab_tag_eff, .first_addr_mask_eff, .second_addr_mask_eff, .irq);
   bpc_cpu_model u_cpu (.mclk, .cyc, .insn_boundary, .tag_exec, .tag_flush);
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // ============================================================
   // access tasks
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge mclk);
      req <= '0;
   endtask
   task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk);
      req <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge mclk);
      req <= '0;
      #1 rd_val = rdata;
      chk(what, rd_val, exp);
   endtask
   task automatic run(input bpc_case_t c);
      wr(8'h25, c.ccx);
      wr(8'h26, c.cch);
      wr(8'h27, 8'h34);
      wr(8'h28, c.c2);
      u_cpu.bus(c.r, c.xa, c.a);
      u_cpu.pipe(c.ev);
      #1 chk("break", {6'h00, brk_swi, brk_bdm}, {6'h00, c.exp});
      @(posedge mclk);
      #1 chk("break end", {6'h00, brk_swi, brk_bdm}, 8'h00);
   endtask
   task automatic eff(input logic [7:0] exp);
      // the effective controls lag a register write by one cycle
      @(posedge mclk);
      #1 chk("effective", {trace_debugger_enable_allowed, 1'b0, full_mode_eff, ab_tag_eff,
         first_addr_mask_eff, second_addr_mask_eff}, exp);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // ============================================================
   // hang guard
   initial
   begin
      repeat (50000) @(posedge mclk);
      error_cnt++;
      finish_test();
   end
   // ============================================================
   // main sequence
   initial
   begin
      rst_n = 1'b0;
      req = '0;
      {arm_pulse, first_loop_capture} = 2'h0;
      trace_debugger_enable_request = 1'b1;
      error_cnt = 0;
      num_checks = 0;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      for (int a = 8'h25; a <= 8'h2b; a++)
         rc("reset", a[7:0], 8'h00);
      rc("unmapped", 8'h30, 8'h00);
      for (int i = 0; i < 5; i++)
         wr(8'h25 + i[7:0], pat[i]);
      wr(8'h2b, 8'h03);
      for (int i = 0; i < 5; i++)
         rc("readback", 8'h25 + i[7:0], pat[i]);
      rc("mask", 8'h2b, 8'h03);
      eff(8'h3f);
      wr(8'h28, 8'h7f);
      rc("trace masks", 8'h29, 8'h30);
      eff(8'h83);
      wr(8'h28, 8'h3f);
      eff(8'h80);
      $display("test registers done");
      foreach (cases[i])
         run(cases[i]);
      $display("test breaks done");
      chk("irq", {7'h00, irq}, 8'h01);
      rc("status", 8'h2a, 8'h03);
      wr(8'h2b, 8'h00);
      @(posedge mclk);
      #1 chk("irq masked", {7'h00, irq}, 8'h00);
      wr(8'h2a, 8'h01);
      rc("status clear", 8'h2a, 8'h02);
      wr(8'h2a, 8'h02);
      wr(8'h2b, 8'h03);
      rc("status empty", 8'h2a, 8'h00);
      chk("irq idle", {7'h00, irq}, 8'h00);
      $display("test interrupt done");
      wr(8'h28, 8'h08);
      first_loop_capture <= 1'b1;
      @(posedge mclk);
      arm_pulse <= 1'b1;
      @(posedge mclk);
      arm_pulse <= 1'b0;
      rc("compare high", 8'h26, 8'h00);
      rc("compare low", 8'h27, 8'h00);
      rc("control", 8'h28, 8'h00);
      run({8'h08, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h0});
      run({8'h88, 8'h00, 8'h12, 1'b0, 8'h00, 16'h1234, 3'h1, 2'h2});
      first_loop_capture <= 1'b0;
      $display("test loop capture done");
      finish_test();
   end
endmodule
